// ---- rtl/scef_socket.sv ----
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module scef_socket import scef_pkg::*; #(
	parameter int TIMEOUT_CYCLES = SCEF_TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// Register port
	input wire logic [7:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	// Protocol engine events, same clock
	input wire scef_evt_s EVT,
	// Protocol engine requests, one cycle pulses
	output scef_act_s ACT,
	// Pointers handed to the engine
	output logic [15:0] TX_FROM,
	output logic [15:0] TX_TO,
	output logic [15:0] RX_FREE_TO,
	// Socket state and event flags as levels
	output logic [7:0] STATE,
	output logic [7:0] FLAGS
);

	// All state in one struct
	typedef struct packed {
		logic [3:0] mode_r;
		logic [7:0] cmd_r;
		logic [7:0] flags_r;
		logic [7:0] mask_r;
		logic [7:0] state_r;
		logic [15:0] txrd_r;
		logic [15:0] txwr_r;
		logic [15:0] rxrd_r;
		logic [15:0] rdata_r;
		scef_act_s act_r;
		scef_seq_e seq_r;
		logic [31:0] tmo_r;
		logic est_seen_r;
	} scef_state_s;

	scef_state_s s_r; // Registered state
	scef_state_s s_nxt; // Next state

	// Read mux, used from the register port only
	function automatic logic [15:0] scef_read(input scef_state_s s, input logic [7:0] a);
		logic [15:0] v;
		v = 16'h0000;
		unique case (a)
			SCEF_OFF_MODE: v = {12'h000, s.mode_r};
			SCEF_OFF_CMD: v = {8'h00, s.cmd_r};
			SCEF_OFF_FLAGS: v = {8'h00, s.flags_r & SCEF_FLAG_USED};
			SCEF_OFF_STATE: v = {8'h00, s.state_r};
			SCEF_OFF_MASK: v = {8'h00, s.mask_r};
			SCEF_OFF_TXRD: v = s.txrd_r;
			SCEF_OFF_TXWR: v = s.txwr_r;
			SCEF_OFF_RXRD: v = s.rxrd_r;
			// Unmapped addresses read zero
			default: v = 16'h0000;
		endcase
		return v;
	endfunction

	// Command decode, exchanges and flags
	always_comb begin
		logic [7:0] ev; // Raw events this cycle
		logic is_tcp;
		logic is_udp;
		logic go_release;
		ev = 8'h00;
		is_tcp = (s_r.mode_r == SCEF_MODE_TCP);
		is_udp = (s_r.mode_r == SCEF_MODE_UDP);
		go_release = 1'b0;
		s_nxt = s_r;
		s_nxt.act_r = '0;
		s_nxt.rdata_r = 16'h0000;
		// A taken command reads back as zero while it runs
		s_nxt.cmd_r = SCEF_CMD_NONE;

		// Engine event sources
		ev[SCEF_BIT_RECEIVED] = EVT.data_rx;
		ev[SCEF_BIT_PEER_FIN] = EVT.fin_rx | EVT.finack_rx;
		ev[SCEF_BIT_TIMEOUT] = EVT.resolve_timeout | EVT.retransmit_timeout;
		// Only the first established edge counts per connection
		if (EVT.established && !s_r.est_seen_r) begin
			ev[SCEF_BIT_CONNECTED] = 1'b1;
			s_nxt.est_seen_r = 1'b1;
			s_nxt.state_r = SCEF_ST_CONNECTED;
		end
		// Peer FIN on an open link moves to half close
		if (EVT.fin_rx && s_r.state_r == SCEF_ST_CONNECTED) begin
			s_nxt.state_r = SCEF_ST_CLOSE_WAIT;
		end

		// Running exchange supervision
		unique case (s_r.seq_r)
			SCEF_IDLE: begin
				s_nxt.tmo_r = 32'h0000_0000;
			end
			SCEF_DISC_WAIT: begin
				if (EVT.finack_rx) begin
					go_release = 1'b1;
				end else if (s_r.tmo_r >= 32'(TIMEOUT_CYCLES - 1)) begin
					// Timeout flag and release in the same cycle
					ev[SCEF_BIT_TIMEOUT] = 1'b1;
					go_release = 1'b1;
				end else begin
					s_nxt.tmo_r = s_r.tmo_r + 32'h0000_0001;
				end
			end
			SCEF_SEND_WAIT: begin
				if (EVT.send_finished) begin
					ev[SCEF_BIT_SEND_DONE] = 1'b1;
					s_nxt.txrd_r = s_r.txwr_r;
					s_nxt.seq_r = SCEF_IDLE;
				end
			end
			SCEF_KEEP_WAIT: begin
				if (EVT.keepalive_reply) begin
					s_nxt.seq_r = SCEF_IDLE;
				end else if (s_r.tmo_r >= 32'(TIMEOUT_CYCLES - 1)) begin
					ev[SCEF_BIT_TIMEOUT] = 1'b1;
					go_release = 1'b1;
				end else begin
					s_nxt.tmo_r = s_r.tmo_r + 32'h0000_0001;
				end
			end
			default: s_nxt.seq_r = SCEF_IDLE;
		endcase

		// Register writes; exchange commands are only taken when idle, close and receive done at any time
		if (WR) begin
			unique case (ADDR)
				SCEF_OFF_MODE: s_nxt.mode_r = WDATA[3:0];
				SCEF_OFF_MASK: s_nxt.mask_r = WDATA[7:0];
				SCEF_OFF_TXWR: s_nxt.txwr_r = WDATA;
				SCEF_OFF_RXRD: s_nxt.rxrd_r = WDATA;
				SCEF_OFF_CMD: begin
					unique case (WDATA[7:0])
						SCEF_CMD_DISCONNECT: begin
							// TCP only; FIN goes out for active and passive close
							if (is_tcp && s_r.seq_r == SCEF_IDLE) begin
								s_nxt.act_r.send_fin = 1'b1;
								s_nxt.state_r = (s_r.state_r == SCEF_ST_CLOSE_WAIT) ?
									SCEF_ST_LAST_ACK : SCEF_ST_FIN_WAIT;
								s_nxt.seq_r = SCEF_DISC_WAIT;
								s_nxt.tmo_r = 32'h0000_0000;
							end
						end
						SCEF_CMD_CLOSE: begin
							go_release = 1'b1;
						end
						SCEF_CMD_SEND: begin
							if (s_r.seq_r == SCEF_IDLE) begin
								s_nxt.act_r.send_data = 1'b1;
								s_nxt.seq_r = SCEF_SEND_WAIT;
							end
						end
						SCEF_CMD_SEND_NO_RESOLVE: begin
							if (is_udp && s_r.seq_r == SCEF_IDLE) begin
								s_nxt.act_r.send_data = 1'b1;
								s_nxt.act_r.skip_resolve = 1'b1;
								s_nxt.seq_r = SCEF_SEND_WAIT;
							end
						end
						SCEF_CMD_KEEPALIVE: begin
							if (is_tcp && s_r.seq_r == SCEF_IDLE) begin
								s_nxt.act_r.send_keepalive = 1'b1;
								s_nxt.seq_r = SCEF_KEEP_WAIT;
								s_nxt.tmo_r = 32'h0000_0000;
							end
						end
						SCEF_CMD_RECEIVE_DONE: begin
							s_nxt.act_r.rx_free = 1'b1;
						end
						// Unknown codes do nothing
						default: s_nxt.act_r = '0;
					endcase
				end
				default: s_nxt.mode_r = s_nxt.mode_r;
			endcase
		end

		// Peer reset overrides state and exchange; same cycle writes and action pulses still take effect
		if (EVT.rst_rx) begin
			go_release = 1'b1;
		end
		if (go_release) begin
			s_nxt.state_r = SCEF_ST_RELEASED;
			s_nxt.seq_r = SCEF_IDLE;
			s_nxt.tmo_r = 32'h0000_0000;
			s_nxt.est_seen_r = 1'b0;
		end

		// Clear by writing ones; a same cycle set still wins
		if (WR && ADDR == SCEF_OFF_FLAGS) begin
			s_nxt.flags_r = s_r.flags_r & ~WDATA[7:0];
		end
		s_nxt.flags_r = (s_nxt.flags_r | (ev & s_r.mask_r)) & SCEF_FLAG_USED;

		// Read data appears one cycle after the strobe
		if (RD) begin
			s_nxt.rdata_r = scef_read(s_r, ADDR);
		end
	end

	// State register
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			s_r <= '0;
			s_r.mask_r <= SCEF_RST_MASK;
			s_r.flags_r <= SCEF_RST_FLAGS;
			s_r.seq_r <= SCEF_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from flops
	assign RDATA = s_r.rdata_r;
	assign ACT = s_r.act_r;
	assign TX_FROM = s_r.txrd_r;
	assign TX_TO = s_r.txwr_r;
	assign RX_FREE_TO = s_r.rxrd_r;
	assign STATE = s_r.state_r;
	assign FLAGS = s_r.flags_r;

endmodule
`default_nettype wire

// ---- rtl/scef_pkg.sv ----
package scef_pkg;

	// Register offsets
	localparam logic [7:0] SCEF_OFF_CMD = 8'h01;
	localparam logic [7:0] SCEF_OFF_FLAGS = 8'h02;
	localparam logic [7:0] SCEF_OFF_STATE = 8'h03;
	localparam logic [7:0] SCEF_OFF_MASK = 8'h2C;
	localparam logic [7:0] SCEF_OFF_MODE = 8'h00;
	localparam logic [7:0] SCEF_OFF_TXRD = 8'h22;
	localparam logic [7:0] SCEF_OFF_TXWR = 8'h24;
	localparam logic [7:0] SCEF_OFF_RXRD = 8'h28;

	// Reset values
	localparam logic [7:0] SCEF_RST_FLAGS = 8'h00;
	localparam logic [7:0] SCEF_RST_MASK = 8'hFF;

	// Command codes
	localparam logic [7:0] SCEF_CMD_NONE = 8'h00;
	localparam logic [7:0] SCEF_CMD_DISCONNECT = 8'h08;
	localparam logic [7:0] SCEF_CMD_CLOSE = 8'h10;
	localparam logic [7:0] SCEF_CMD_SEND = 8'h20;
	localparam logic [7:0] SCEF_CMD_SEND_NO_RESOLVE = 8'h21;
	localparam logic [7:0] SCEF_CMD_KEEPALIVE = 8'h22;
	localparam logic [7:0] SCEF_CMD_RECEIVE_DONE = 8'h40;

	// Mode field codes
	localparam logic [3:0] SCEF_MODE_TCP = 4'h1;
	localparam logic [3:0] SCEF_MODE_UDP = 4'h2;

	// Socket state codes
	localparam logic [7:0] SCEF_ST_RELEASED = 8'h00;
	localparam logic [7:0] SCEF_ST_CONNECTED = 8'h17;
	localparam logic [7:0] SCEF_ST_CLOSE_WAIT = 8'h1C;
	localparam logic [7:0] SCEF_ST_FIN_WAIT = 8'h18;
	localparam logic [7:0] SCEF_ST_LAST_ACK = 8'h1D;
	localparam logic [7:0] SCEF_ST_UDP = 8'h22;

	// Event flag bit positions
	localparam int SCEF_BIT_CONNECTED = 0;
	localparam int SCEF_BIT_PEER_FIN = 1;
	localparam int SCEF_BIT_RECEIVED = 2;
	localparam int SCEF_BIT_TIMEOUT = 3;
	localparam int SCEF_BIT_SEND_DONE = 4;
	localparam logic [7:0] SCEF_FLAG_USED = 8'h1F;

	// Timing: probe and disconnect wait before timeout
	localparam int SCEF_TIMEOUT_US = 200;
	localparam int SCEF_CLK_MHZ = 250;
	localparam int SCEF_TIMEOUT_CYC = SCEF_TIMEOUT_US * SCEF_CLK_MHZ;

	// Bus request from host
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} scef_bus_s;

	// Protocol engine events toward this block
	typedef struct packed {
		logic fin_rx;
		logic finack_rx;
		logic rst_rx;
		logic data_rx;
		logic established;
		logic resolve_timeout;
		logic retransmit_timeout;
		logic keepalive_reply;
		logic send_finished;
	} scef_evt_s;

	// Engine action requests from this block
	typedef struct packed {
		logic send_fin;
		logic send_data;
		logic skip_resolve;
		logic send_keepalive;
		logic rx_free;
	} scef_act_s;

	// Command sequencing states
	typedef enum logic [2:0] {
		SCEF_IDLE,
		SCEF_DISC_WAIT,
		SCEF_SEND_WAIT,
		SCEF_KEEP_WAIT
	} scef_seq_e;

endpackage

// ---- test/scef_chk_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module scef_chk import scef_pkg::*; (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// Register port
	input wire logic [7:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	// Engine side
	input wire scef_evt_s EVT,
	input wire scef_act_s ACT,
	// State and flags
	input wire logic [7:0] STATE,
	input wire logic [7:0] FLAGS
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	// Host writes one command code
	sequence s_cmd(c);
		WR && ADDR == SCEF_OFF_CMD && WDATA[7:0] == c;
	endsequence
	// Socket waits in a closing exchange
	sequence s_closing;
		STATE == SCEF_ST_FIN_WAIT || STATE == SCEF_ST_LAST_ACK;
	endsequence
	a_close_release: assert property (s_cmd(SCEF_CMD_CLOSE) |=> STATE == 8'h00)
		else $error("close kept state");
	a_peer_reset: assert property (EVT.rst_rx |=> STATE == 8'h00)
		else $error("peer reset kept state");
	a_fin_state: assert property (ACT.send_fin |-> s_closing)
		else $error("fin outside closing");
	a_finack_close: assert property (s_closing ##0 EVT.finack_rx |=> STATE == 8'h00)
		else $error("finack kept state");
	a_rsvd_zero: assert property (FLAGS[7:5] == 3'h0)
		else $error("reserved flag set");
	a_send_flag: assert property ($rose(FLAGS[4]) |-> $past(EVT.send_finished))
		else $error("send flag without cause");
	a_rx_flag: assert property ($rose(FLAGS[2]) |-> $past(EVT.data_rx))
		else $error("receive flag without cause");
	a_con_flag: assert property ($rose(FLAGS[0]) |-> STATE == SCEF_ST_CONNECTED)
		else $error("connect flag without link");
	a_clear_keep: assert property (WR && ADDR == SCEF_OFF_FLAGS && !WDATA[0] && FLAGS[0]
		|=> FLAGS[0])
		else $error("zero write cleared flag");
endmodule
bind scef_socket scef_chk scef_chk_i (.*);
`default_nettype wire

// ---- test/scef_engine.sv ----
`timescale 1ns/10ps
`default_nettype none
module scef_engine import scef_pkg::*; (
	// Clock
	input wire logic MCLK,
	// Requests and bench controls
	input wire scef_act_s ACT,
	input wire logic MUTE,
	input wire logic [8:0] INJ,
	// Events back to the block
	output scef_evt_s EVT
);
	// Fixed three cycle answer delay for data, FIN and keepalive requests
	logic [2:0] d_send = '0, d_fin = '0, d_keep = '0;
	always_ff @(posedge MCLK) begin
		d_send <= {d_send[1:0], ACT.send_data};
		d_fin <= {d_fin[1:0], ACT.send_fin};
		d_keep <= {d_keep[1:0], ACT.send_keepalive};
	end
	// A muted peer sends no FIN ACK or keepalive reply, which forces the timeout paths
	always_comb begin
		EVT = scef_evt_s'(INJ);
		EVT.send_finished = EVT.send_finished | d_send[2];
		EVT.finack_rx = EVT.finack_rx | (d_fin[2] & !MUTE);
		EVT.keepalive_reply = EVT.keepalive_reply | (d_keep[2] & !MUTE);
	end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top import scef_pkg::*;;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, mute = 0;
	logic [7:0] addr = '0;
	logic [15:0] wdata = '0, rdata, got, txf, txt, rxf;
	logic [8:0] inj = '0;
	logic [7:0] st, fl;
	scef_evt_s evt;
	scef_act_s act;
	int num_errors = 0, checked = 0;
	scef_socket #(.TIMEOUT_CYCLES(16)) scef_socket_i (.MCLK(clk), .RST_N(rst_n), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .EVT(evt), .ACT(act),
		.TX_FROM(txf), .TX_TO(txt), .RX_FREE_TO(rxf), .STATE(st), .FLAGS(fl));
	scef_engine scef_engine_i (.MCLK(clk), .ACT(act), .MUTE(mute), .INJ(inj), .EVT(evt));
	initial begin
		forever #2 clk = ~clk;
	end
	// Register write, one strobe cycle
	task wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	// Register read, data taken in the following cycle
	task rd_reg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 got = rdata;
	endtask
	task cmd(input logic [7:0] c);
		wr_reg(SCEF_OFF_CMD, {8'h00, c});
	endtask
	task pulse(input logic [8:0] e);
		@(posedge clk) inj <= e;
		@(posedge clk) inj <= '0;
		#1;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task t_close;
		rd_reg(SCEF_OFF_FLAGS);
		`CHK(got, 16'h0000)
		wr_reg(SCEF_OFF_MODE, 16'h0001);
		pulse(9'h010);
		`CHK(st, SCEF_ST_CONNECTED)
		`CHK(fl, 8'h01)
		cmd(SCEF_CMD_CLOSE);
		`CHK(st, 8'h00)
		rd_reg(SCEF_OFF_CMD);
		`CHK(got, 16'h0000)
		$display("t_close done");
	endtask
	task t_disc;
		wr_reg(SCEF_OFF_FLAGS, 16'h00FF);
		pulse(9'h010);
		cmd(SCEF_CMD_DISCONNECT);
		`CHK(act.send_fin, 1'b1)
		`CHK(st, SCEF_ST_FIN_WAIT)
		tick(8);
		`CHK(st, 8'h00)
		`CHK(fl[1], 1'b1)
		$display("t_disc done");
	endtask
	// Silent peer: passive close and probe both time out
	task t_pass;
		pulse(9'h010);
		pulse(9'h100);
		`CHK(st, SCEF_ST_CLOSE_WAIT)
		mute <= 1'b1;
		cmd(SCEF_CMD_DISCONNECT);
		`CHK(act.send_fin, 1'b1)
		`CHK(st, SCEF_ST_LAST_ACK)
		tick(24);
		`CHK(fl[3], 1'b1)
		`CHK(st, 8'h00)
		wr_reg(SCEF_OFF_FLAGS, 16'h0000);
		`CHK(fl[3], 1'b1)
		wr_reg(SCEF_OFF_FLAGS, 16'h0008);
		`CHK(fl[3], 1'b0)
		pulse(9'h010);
		cmd(SCEF_CMD_KEEPALIVE);
		`CHK(act.send_keepalive, 1'b1)
		tick(24);
		`CHK(st, 8'h00)
		`CHK(fl[3], 1'b1)
		mute <= 1'b0;
		$display("t_pass done");
	endtask
	task t_send;
		pulse(9'h010);
		wr_reg(SCEF_OFF_TXWR, 16'h0040);
		cmd(SCEF_CMD_SEND);
		`CHK(act.send_data, 1'b1)
		tick(8);
		`CHK(fl[4], 1'b1)
		`CHK(txf, 16'h0040)
		`CHK(txt, 16'h0040)
		cmd(SCEF_CMD_SEND_NO_RESOLVE);
		`CHK(act, 5'h00)
		wr_reg(SCEF_OFF_MODE, 16'h0002);
		cmd(SCEF_CMD_DISCONNECT);
		`CHK(act, 5'h00)
		cmd(SCEF_CMD_SEND_NO_RESOLVE);
		`CHK(act.skip_resolve & act.send_data, 1'b1)
		tick(8);
		wr_reg(SCEF_OFF_RXRD, 16'h0010);
		cmd(SCEF_CMD_RECEIVE_DONE);
		`CHK(act.rx_free, 1'b1)
		`CHK(rxf, 16'h0010)
		$display("t_send done");
	endtask
	// Masked receive event leaves its flag clear
	task t_mask;
		wr_reg(SCEF_OFF_FLAGS, 16'h00FF);
		pulse(9'h008);
		`CHK(fl[3], 1'b1)
		wr_reg(SCEF_OFF_FLAGS, 16'h0008);
		pulse(9'h004);
		`CHK(fl[3], 1'b1)
		wr_reg(SCEF_OFF_FLAGS, 16'h00FF);
		wr_reg(SCEF_OFF_MASK, 16'h00FB);
		pulse(9'h020);
		`CHK(fl[2], 1'b0)
		wr_reg(SCEF_OFF_MASK, 16'h00FF);
		pulse(9'h020);
		`CHK(fl[2], 1'b1)
		pulse(9'h010);
		pulse(9'h040);
		`CHK(st, 8'h00)
		$display("t_mask done");
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_close;
		t_disc;
		t_pass;
		t_send;
		t_mask;
		give_verdict;
	end
	// Watchdog far beyond the roughly 150 cycles the tests need
	initial begin
		#20000;
		num_errors++;
		give_verdict;
	end
endmodule
`default_nettype wire
